// ===== design/core_tail_params.svh
// Offsets, field positions, encodings and reset values of the core tail
`ifndef CORE_TAIL_PARAMS_SVH
`define CORE_TAIL_PARAMS_SVH
// Register word indices (byte address = index * 4)
`define REG_CTRL       4'h0
`define REG_ACC        4'h1
`define REG_STATUS     4'h2
`define REG_OPTION     4'h3
`define REG_IRQ_CTRL   4'h4
`define REG_DIR        4'h5
`define REG_PC         4'h6
`define REG_WATCHDOG   4'h7
`define REG_FILE_ADDR  4'h8
`define REG_FILE_DATA  4'h9
`define REG_STACK_PUSH 4'ha
// Field positions
`define CTRL_RUN_BIT   0
`define CTRL_WAKE_BIT  1
`define IRQ_ENABLE_BIT 7
// Full-word encodings
`define OP_RET_SUB     14'h0008
`define OP_RET_IRQ     14'h0009
`define OP_OPTION      14'h0062
`define OP_SLEEP       14'h0063
// Prefix encodings
`define OP_DIR_TOP     11'h00c
`define OP_RET_LIT     4'hd
`define OP_SUB_LIT     5'h1e
`define OP_XOR_LIT     6'h3a
`define OP_SUB_FILE    6'h02
`define OP_XOR_FILE    6'h06
`define OP_ROT_RIGHT   6'h0c
`define OP_ROT_LEFT    6'h0d
`define OP_NIB_SWAP    6'h0e
`define DIR_SEL_LO     3'h5
// Reset values
`define RST_ACC        8'h00
`define RST_OPTION     8'hff
`define RST_IRQ_CTRL   8'h00
`define RST_DIR        8'hff
`define RST_PC         13'h0000
// Power-down and expired flags read 1 after reset, the rest 0
`define RST_STATUS     5'h18
`endif

// ===== design/core_tail_pkg.sv
// Types shared by the core tail
package core_tail_pkg;
	typedef enum logic [1:0] {ST_EXEC, ST_FLUSH, ST_HALT} core_state_t;
	typedef struct packed {
		logic power_down_flag;
		logic watchdog_expired_flag;
		logic z;
		logic nibble_carry_flag;
		logic c;
	} status_t;
endpackage

// ===== design/core_tail.sv
// Execute logic for the return, rotate, subtract, swap and xor group
//
// Functional notes
// - Option opcode copies accumulator, flags kept
// - Interrupt return pops stack, sets global enable
// - Literal return loads literal, pops stack
// - Subroutine return pops stack, two cycles
// - Rotate left through carry, carry only
// - Rotate right through carry, carry only
// - Bit d picks accumulator or file
// - Sleep clears watchdog counter and prescaler
// - Sleep sets expired, clears power-down, halts
// - Literal minus accumulator, sets carry, nibble, zero
// - File minus accumulator routed by d
// - Carry is inverted borrow; zero on zero
// - Nibble exchange routed by d, no flags
// - Direction load copies accumulator, f 5-7
// - Xor forms update only zero flag
`timescale 1ns/1ps
`include "core_tail_params.svh"
module core_tail
	import core_tail_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rstn,
	input  wire logic [5:0]  address,
	input  wire logic        read,
	input  wire logic        write,
	input  wire logic [31:0] writedata,
	input  wire logic [3:0]  byteenable,
	output logic      [31:0] readdata,
	output logic             waitrequest,
	input  wire logic [13:0] instr_word,
	input  wire logic        instr_valid,
	output logic      [12:0] fetch_pc,
	output logic             halted,
	output logic             osc_stop,
	output logic             global_irq_enable
);
	// ------------------------------------------------------------
	// Architectural state
	// ------------------------------------------------------------
	core_state_t state;
	status_t     status;
	logic [7:0]  acc;
	logic [7:0]  option_reg;
	logic [7:0]  irq_control_reg;
	logic [7:0]  port_direction_reg [5:7];
	logic [7:0]  file_mem [0:127];
	logic [12:0] stack_mem [0:7];
	logic [2:0]  sp;
	logic [7:0]  watchdog_counter;
	logic [7:0]  watchdog_prescale;
	logic        run;
	logic [6:0]  file_addr;

	// ------------------------------------------------------------
	// Avalon slave: one wait cycle, then answer
	// ------------------------------------------------------------
	logic        bus_req;
	logic        bus_take;
	logic        bus_wr;
	logic [3:0]  bus_idx;
	logic        mapped;
	logic [31:0] bus_rdata;
	logic [31:0] be_mask;
	logic [31:0] wr_val;

	assign bus_req  = read | write;
	assign bus_take = bus_req & ~waitrequest;
	assign bus_idx  = address[5:2];
	assign mapped   = bus_idx <= `REG_STACK_PUSH;
	assign bus_wr   = write & ~waitrequest & mapped;

	// Waitrequest drops for exactly one cycle per request
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			waitrequest <= 1'b1;
		else
			waitrequest <= ~(bus_req & waitrequest);
	end

	// Readback of every mapped word except stack push; it and unmapped read as zero
	always_comb begin
		bus_rdata = 32'h0000_0000;
		unique case (bus_idx)
			`REG_CTRL:      bus_rdata[`CTRL_RUN_BIT] = run;
			`REG_ACC:       bus_rdata[7:0] = acc;
			`REG_STATUS:    bus_rdata[5:0] = {halted, status};
			`REG_OPTION:    bus_rdata[7:0] = option_reg;
			`REG_IRQ_CTRL:  bus_rdata[7:0] = irq_control_reg;
			`REG_DIR:       bus_rdata[23:0] = {port_direction_reg[7],
				port_direction_reg[6], port_direction_reg[5]};
			`REG_PC:        bus_rdata[12:0] = fetch_pc;
			`REG_WATCHDOG:  bus_rdata[15:0] = {watchdog_prescale,
				watchdog_counter};
			`REG_FILE_ADDR: bus_rdata[6:0] = file_addr;
			`REG_FILE_DATA: bus_rdata[7:0] = file_mem[file_addr];
			default:        bus_rdata = 32'h0000_0000;
		endcase
	end

	// Byte lanes merge the write into the present value
	assign be_mask = {{8{byteenable[3]}}, {8{byteenable[2]}},
		{8{byteenable[1]}}, {8{byteenable[0]}}};
	assign wr_val  = (bus_rdata & ~be_mask) | (writedata & be_mask);

	// Read data is captured on the edge that ends the wait cycle
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			readdata <= 32'h0000_0000;
		else if (read & waitrequest)
			readdata <= bus_rdata;
	end

	// Run enable and file window pointer
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			run       <= 1'b0;
			file_addr <= 7'h00;
		end else if (bus_wr) begin
			if (bus_idx == `REG_CTRL)
				run <= wr_val[`CTRL_RUN_BIT];
			if (bus_idx == `REG_FILE_ADDR)
				file_addr <= wr_val[6:0];
		end
	end

	// ------------------------------------------------------------
	// Decode and datapath
	// ------------------------------------------------------------
	logic        exec_en;
	logic [6:0]  fa;
	logic [7:0]  lit;
	logic [7:0]  fval;
	logic        dest_file;
	logic [12:0] stack_top;
	logic        is_ret_sub, is_ret_irq, is_option, is_sleep;
	logic        is_dir, is_ret_lit, is_sub_lit, is_xor_lit;
	logic        is_sub_file, is_xor_file, is_rot_r, is_rot_l;
	logic        is_swap, file_form, two_cycle;
	logic [7:0]  sub_a;
	logic [8:0]  sub_sum;
	logic [4:0]  nib_sum;
	logic [7:0]  result;
	logic        acc_we;
	logic        file_we;
	status_t     next_status;

	// The core stalls while a bus write lands, so state has one writer
	assign exec_en   = run & instr_valid & (state == ST_EXEC) & ~bus_wr;
	assign fa        = instr_word[6:0];
	assign lit       = instr_word[7:0];
	assign fval      = file_mem[fa];
	assign dest_file = instr_word[7];
	assign stack_top = stack_mem[sp - 3'd1];

	assign is_ret_sub  = instr_word == `OP_RET_SUB;
	assign is_ret_irq  = instr_word == `OP_RET_IRQ;
	assign is_option   = instr_word == `OP_OPTION;
	assign is_sleep    = instr_word == `OP_SLEEP;
	// Only selectors 5 to 7 name a direction register
	assign is_dir      = (instr_word[13:3] == `OP_DIR_TOP) &&
		(instr_word[2:0] >= `DIR_SEL_LO);
	assign is_ret_lit  = instr_word[13:10] == `OP_RET_LIT;
	assign is_sub_lit  = instr_word[13:9] == `OP_SUB_LIT;
	assign is_xor_lit  = instr_word[13:8] == `OP_XOR_LIT;
	assign is_sub_file = instr_word[13:8] == `OP_SUB_FILE;
	assign is_xor_file = instr_word[13:8] == `OP_XOR_FILE;
	assign is_rot_r    = instr_word[13:8] == `OP_ROT_RIGHT;
	assign is_rot_l    = instr_word[13:8] == `OP_ROT_LEFT;
	assign is_swap     = instr_word[13:8] == `OP_NIB_SWAP;
	assign file_form   = is_sub_file | is_xor_file | is_rot_r |
		is_rot_l | is_swap;
	assign two_cycle   = is_ret_sub | is_ret_irq | is_ret_lit;

	// Two's complement subtract: a + ~acc + 1, carry out is not-borrow
	assign sub_a   = is_sub_lit ? lit : fval;
	assign sub_sum = {1'b0, sub_a} + {1'b0, ~acc} + 9'h001;
	assign nib_sum = {1'b0, sub_a[3:0]} + {1'b0, ~acc[3:0]} + 5'h01;

	// Result, destination and flag effects per opcode
	always_comb begin
		result      = 8'h00;
		next_status = status;
		if (is_rot_l) begin
			result        = {fval[6:0], status.c};
			next_status.c = fval[7];
		end else if (is_rot_r) begin
			result        = {status.c, fval[7:1]};
			next_status.c = fval[0];
		end else if (is_sub_lit | is_sub_file) begin
			result         = sub_sum[7:0];
			next_status.c  = sub_sum[8];
			next_status.nibble_carry_flag = nib_sum[4];
			next_status.z  = sub_sum[7:0] == 8'h00;
		end else if (is_swap) begin
			result = {fval[3:0], fval[7:4]};
		end else if (is_xor_lit | is_xor_file) begin
			result        = acc ^ (is_xor_lit ? lit : fval);
			next_status.z = result == 8'h00;
		end else if (is_ret_lit) begin
			result = lit;
		end else if (is_sleep) begin
			next_status.watchdog_expired_flag = 1'b1;
			next_status.power_down_flag       = 1'b0;
		end
	end

	// Bit d routes file-form results; literal forms go to accumulator
	assign file_we = exec_en & file_form & dest_file;
	assign acc_we  = exec_en & ((file_form & ~dest_file) |
		is_sub_lit | is_xor_lit | is_ret_lit);

	// ------------------------------------------------------------
	// Sequencing: execute, flush, halt
	// ------------------------------------------------------------
	// The flush cycle throws the prefetched word away and writes nothing
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			state    <= ST_EXEC;
			fetch_pc <= `RST_PC;
			halted   <= 1'b0;
			osc_stop <= 1'b0;
		end else begin
			unique case (state)
				ST_EXEC: if (exec_en) begin
					if (two_cycle) begin
						fetch_pc <= stack_top;
						state    <= ST_FLUSH;
					end else begin
						fetch_pc <= fetch_pc + 13'h0001;
					end
					if (is_sleep) begin
						state    <= ST_HALT;
						halted   <= 1'b1;
						osc_stop <= 1'b1;
					end
				end
				ST_FLUSH: state <= ST_EXEC;
				ST_HALT: if (bus_wr && bus_idx == `REG_CTRL &&
						wr_val[`CTRL_WAKE_BIT]) begin
					state    <= ST_EXEC;
					halted   <= 1'b0;
					osc_stop <= 1'b0;
				end
			endcase
		end
	end

	// Accumulator and status
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			acc    <= `RST_ACC;
			status <= `RST_STATUS;
		end else if (bus_wr && bus_idx == `REG_ACC) begin
			acc <= wr_val[7:0];
		end else if (exec_en) begin
			if (acc_we)
				acc <= result;
			status <= next_status;
		end
	end

	// Option, interrupt control and direction loads
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			option_reg      <= `RST_OPTION;
			irq_control_reg <= `RST_IRQ_CTRL;
			for (int i = 5; i <= 7; i++)
				port_direction_reg[i] <= `RST_DIR;
		end else if (bus_wr && bus_idx == `REG_IRQ_CTRL) begin
			irq_control_reg <= wr_val[7:0];
		end else if (exec_en) begin
			if (is_option)
				option_reg <= acc;
			if (is_ret_irq)
				irq_control_reg[`IRQ_ENABLE_BIT] <= 1'b1;
			if (is_dir)
				port_direction_reg[instr_word[2:0]] <= acc;
		end
	end

	// Global enable mirrors its control bit from a flop
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			global_irq_enable <= 1'b0;
		else if (bus_wr && bus_idx == `REG_IRQ_CTRL)
			global_irq_enable <= wr_val[`IRQ_ENABLE_BIT];
		else if (exec_en && is_ret_irq)
			global_irq_enable <= 1'b1;
	end

	// File registers: no reset, software initialises them
	always_ff @(posedge clk) begin
		if (bus_wr && bus_idx == `REG_FILE_DATA)
			file_mem[file_addr] <= wr_val[7:0];
		else if (file_we)
			file_mem[fa] <= result;
	end

	// Return stack; software pushes stand in for calls
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			sp <= 3'd0;
		end else if (bus_wr && bus_idx == `REG_STACK_PUSH) begin
			stack_mem[sp] <= wr_val[12:0];
			sp            <= sp + 3'd1;
		end else if (exec_en && two_cycle) begin
			sp <= sp - 3'd1;
		end
	end

	// Watchdog prescaler ticks every cycle while not halted, counter once per 256; sleep clears counter and prescaler
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			watchdog_counter  <= 8'h00;
			watchdog_prescale <= 8'h00;
		end else if (exec_en && is_sleep) begin
			watchdog_counter  <= 8'h00;
			watchdog_prescale <= 8'h00;
		end else if (!halted) begin
			watchdog_prescale <= watchdog_prescale + 8'h01;
			if (watchdog_prescale == 8'hff)
				watchdog_counter <= watchdog_counter + 8'h01;
		end
	end

	// ------------------------------------------------------------
	// Assertions and covers
	// ------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	a_option_load: assert property (
		exec_en && is_option |=> option_reg == $past(acc) &&
		status == $past(status)) else $error("option load wrong");
	a_irq_exit_gie: assert property (
		exec_en && is_ret_irq |=> global_irq_enable &&
		fetch_pc == $past(stack_top)) else $error("irq exit wrong");
	a_literal_exit: assert property (
		exec_en && is_ret_lit |=> acc == $past(lit) &&
		status == $past(status)) else $error("literal exit wrong");
	a_sub_return: assert property (
		exec_en && is_ret_sub |=> state == ST_FLUSH ##1
		state == ST_EXEC) else $error("return not two cycles");
	a_rotate_left: assert property (
		exec_en && is_rot_l |=> status.c == $past(fval[7]) &&
		status.z == $past(status.z)) else $error("rotate left carry");
	a_rotate_right: assert property (
		exec_en && is_rot_r && !dest_file |=> status.c == $past(fval[0])
		&& acc[7] == $past(status.c)) else $error("rotate right");
	a_swap_dest: assert property (
		exec_en && is_swap && !dest_file |=> acc ==
		{$past(fval[3:0]), $past(fval[7:4])}) else $error("swap to acc");
	a_sleep_watchdog: assert property (
		exec_en && is_sleep |=> watchdog_counter == 8'h00 &&
		watchdog_prescale == 8'h00) else $error("watchdog not cleared");
	a_sleep_halt: assert property (
		exec_en && is_sleep |=> halted && osc_stop &&
		status.watchdog_expired_flag && !status.power_down_flag)
		else $error("sleep entry wrong");
	a_lit_sub_carry: assert property (
		exec_en && is_sub_lit |=> status.c == ($past(lit) >= $past(acc))
		&& acc == $past(lit) - $past(acc)) else $error("literal sub");
	a_file_sub_zero: assert property (
		exec_en && is_sub_file |=> status.z == ($past(fval) ==
		$past(acc))) else $error("file sub zero flag");
	a_sub_borrow: assert property (
		exec_en && is_sub_file |=> status.c == ($past(fval) >=
		$past(acc))) else $error("borrow sense wrong");
	a_swap_flags: assert property (
		exec_en && is_swap |=> status == $past(status))
		else $error("swap touched flags");
	a_dir_load: assert property (
		exec_en && is_dir |=> port_direction_reg[$past(instr_word[2:0])]
		== $past(acc)) else $error("direction load wrong");
	a_xor_flags: assert property (
		exec_en && is_xor_lit |=> acc == ($past(acc) ^ $past(lit)) &&
		status.c == $past(status.c)) else $error("xor wrong");
	a_flush_quiet: assert property (
		state == ST_FLUSH && !bus_wr |=> acc == $past(acc) &&
		fetch_pc == $past(fetch_pc)) else $error("flush cycle wrote");

	c_irq_exit: cover property (exec_en && is_ret_irq ##2 exec_en);
	c_sub_neg: cover property (exec_en && is_sub_lit && !sub_sum[8]);
	c_sleep_wake: cover property (state == ST_HALT ##[1:20]
		state == ST_EXEC);
	c_swap_file: cover property (exec_en && is_swap && dest_file);
endmodule

// ===== testbench/prog_mem.sv
// Program memory model feeding fetched words to the core
`timescale 1ns/1ps
module prog_mem (
	input  wire logic        clk,
	input  wire logic        rstn,
	input  wire logic [12:0] fetch_pc,
	input  wire logic        en,
	output logic      [13:0] instr_word,
	output logic             instr_valid
);
	logic [13:0] mem [8192];
	logic [13:0] last;

	// Bench places words here before each step
	task automatic load(input logic [12:0] a, input logic [13:0] w);
		mem[a] = w;
	endtask

	// Last word shown, so idle cycles never echo it
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			last <= 14'h0000;
		else if (en)
			last <= instr_word;
	end

	// Idle word is inverted: a stale word must not look valid
	assign instr_valid = en;
	assign instr_word  = en ? mem[fetch_pc] : ~last;
endmodule

// ===== testbench/tb_top.sv
// Self-checking bench for the core tail execute block
`timescale 1ns/1ps
`include "core_tail_params.svh"
module tb_top;
	import core_tail_pkg::*;
	typedef struct packed {
		logic [13:0] ins;
		logic [6:0]  fa;
		logic [7:0]  ain;
		logic [7:0]  fin;
		logic [7:0]  eacc;
		logic [7:0]  efile;
		logic [2:0]  est;
	} row_t;
	logic        clk;
	logic        rstn;
	logic [5:0]  address;
	logic        read;
	logic        write;
	logic [31:0] writedata;
	logic [31:0] readdata;
	logic        waitrequest;
	logic [13:0] instr_word;
	logic        instr_valid;
	logic [12:0] fetch_pc;
	logic        halted;
	logic        osc_stop;
	logic        global_irq_enable;
	logic        en;
	logic [3:0]  be;
	logic [12:0] pc;
	logic [12:0] ret_addr;
	row_t        rows [13];
	logic [13:0] ret_ops [3];
	int          err_total;
	int          samples_checked;

	core_tail u_core_tail (.clk(clk), .rstn(rstn), .address(address),
		.read(read), .write(write), .writedata(writedata),
		.byteenable(be), .readdata(readdata), .waitrequest(waitrequest),
		.instr_word(instr_word), .instr_valid(instr_valid),
		.fetch_pc(fetch_pc), .halted(halted), .osc_stop(osc_stop),
		.global_irq_enable(global_irq_enable));
	prog_mem u_prog_mem (.clk(clk), .rstn(rstn), .fetch_pc(fetch_pc),
		.en(en), .instr_word(instr_word), .instr_valid(instr_valid));

	always #12.5 clk = ~clk;

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] %0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// One Avalon transfer; request held until waitrequest seen low
	// No local limit: only the watchdog may end a hung wait
	task automatic bus(input logic wr, input logic [3:0] idx,
			input logic [31:0] d, output logic [31:0] q);
		address <= {idx, 2'b00};
		write <= wr;
		read <= !wr;
		writedata <= d;
		do
			@(posedge clk);
		while (waitrequest !== 1'b0);
		q = readdata;
		write <= 1'b0;
		read <= 1'b0;
		@(posedge clk);
	endtask

	task automatic wr(input logic [3:0] idx, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, idx, d, q);
	endtask

	task automatic rd_chk(input logic [3:0] idx, input logic [31:0] m,
			input logic [31:0] e);
		logic [31:0] q;
		bus(1'b0, idx, 32'h0, q);
		chk(q & m, e);
	endtask

	// Offer words for exactly n edges, then go idle
	task automatic step(input int n);
		en <= 1'b1;
		repeat (n) @(posedge clk);
		en <= 1'b0;
		@(posedge clk);
	endtask

	task automatic results;
		$display("errors %0d checks %0d", err_total, samples_checked);
		if (err_total == 0 && samples_checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// Watchdog: the whole run needs well under 3000 cycles
	initial begin
		repeat (5000) @(posedge clk);
		err_total++;
		results();
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		clk = 1'b0;
		rstn = 1'b0;
		address = 6'h00;
		read = 1'b0;
		write = 1'b0;
		writedata = 32'h0;
		en = 1'b0;
		be = 4'hf;
		pc = 13'h0000;
		err_total = 0;
		samples_checked = 0;
		// Carry chains from row to row; est is {z, dc, c}
		rows = '{
			'{{6'h0d, 1'b0, 7'h25}, 7'h25, 8'h00, 8'he6, 8'hcc, 8'he6, 3'h1},
			'{{6'h0c, 1'b1, 7'h7f}, 7'h7f, 8'h11, 8'he6, 8'h11, 8'hf3, 3'h0},
			'{{6'h02, 1'b1, 7'h25}, 7'h25, 8'h02, 8'h03, 8'h02, 8'h01, 3'h3},
			'{{6'h02, 1'b0, 7'h25}, 7'h25, 8'h02, 8'h02, 8'h00, 8'h02, 3'h7},
			'{{6'h02, 1'b0, 7'h25}, 7'h25, 8'h02, 8'h01, 8'hff, 8'h01, 3'h0},
			'{{5'h1e, 1'b0, 8'h01}, 7'h25, 8'h02, 8'h5a, 8'hff, 8'h5a, 3'h0},
			'{{5'h1e, 1'b1, 8'h02}, 7'h25, 8'h02, 8'h5a, 8'h00, 8'h5a, 3'h7},
			'{{6'h0e, 1'b0, 7'h25}, 7'h25, 8'h33, 8'ha5, 8'h5a, 8'ha5, 3'h7},
			'{{6'h0e, 1'b1, 7'h25}, 7'h25, 8'h33, 8'h0f, 8'h33, 8'hf0, 3'h7},
			'{{6'h3a, 8'haf}, 7'h25, 8'hb5, 8'h00, 8'h1a, 8'h00, 3'h3},
			'{{6'h06, 1'b1, 7'h25}, 7'h25, 8'hb5, 8'haf, 8'hb5, 8'h1a, 3'h3},
			'{{6'h06, 1'b0, 7'h25}, 7'h25, 8'h77, 8'h77, 8'h00, 8'h77, 3'h7},
			'{{6'h0d, 1'b1, 7'h25}, 7'h25, 8'h00, 8'h7f, 8'h00, 8'hff, 3'h6}};
		ret_ops = '{14'h0008, {4'hd, 2'b00, 8'h5c}, 14'h0009};
		repeat (5) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		chk({28'h0, halted, osc_stop, global_irq_enable, waitrequest}, 32'h1);
		rd_chk(`REG_OPTION, 32'hff, 32'hff);
		rd_chk(`REG_DIR, 32'hffffff, 32'hffffff);
		rd_chk(`REG_STATUS, 32'h3f, 32'h18);
		rd_chk(4'hb, 32'hffffffff, 32'h0);
		wr(`REG_CTRL, 32'h1);
		// Table of one-cycle arithmetic, rotate, swap and xor cases
		for (int i = 0; i < 13; i++) begin
			wr(`REG_ACC, {24'h0, rows[i].ain});
			wr(`REG_FILE_ADDR, {25'h0, rows[i].fa});
			wr(`REG_FILE_DATA, {24'h0, rows[i].fin});
			u_prog_mem.load(pc, rows[i].ins);
			step(1);
			pc++;
			rd_chk(`REG_ACC, 32'hff, {24'h0, rows[i].eacc});
			rd_chk(`REG_FILE_DATA, 32'hff, {24'h0, rows[i].efile});
			rd_chk(`REG_STATUS, 32'h7, {29'h0, rows[i].est});
			rd_chk(`REG_PC, 32'h1fff, {19'h0, pc});
		end
		// Option load keeps flags from the last row
		wr(`REG_ACC, 32'h3c);
		u_prog_mem.load(pc, `OP_OPTION);
		step(1);
		pc++;
		rd_chk(`REG_OPTION, 32'hff, 32'h3c);
		rd_chk(`REG_STATUS, 32'h7, 32'h6);
		// Direction loads for every legal selector
		for (int f = 5; f < 8; f++) begin
			wr(`REG_ACC, 32'h10 + f);
			u_prog_mem.load(pc, 14'h0060 | 14'(f));
			step(1);
			pc++;
		end
		rd_chk(`REG_DIR, 32'hffffff, 32'h171615);
		// Each return, with the word after it offered during the flush
		for (int k = 0; k < 3; k++) begin
			ret_addr = 13'h0100 + 13'(k * 16);
			wr(`REG_ACC, 32'h11);
			wr(`REG_STACK_PUSH, {19'h0, ret_addr});
			u_prog_mem.load(pc, ret_ops[k]);
			u_prog_mem.load(ret_addr, 14'h3aff);
			u_prog_mem.load(ret_addr + 13'h1, 14'h3a0f);
			step(3);
			pc = ret_addr + 13'h1;
			rd_chk(`REG_PC, 32'h1fff, {19'h0, pc});
			rd_chk(`REG_ACC, 32'hff, (k == 1) ? 32'ha3 : 32'hee);
			chk({31'h0, global_irq_enable}, (k == 2) ? 32'h1 : 32'h0);
		end
		rd_chk(`REG_IRQ_CTRL, 32'h80, 32'h80);
		// Sleep, an ignored word while halted, then wake
		u_prog_mem.load(pc, `OP_SLEEP);
		step(1);
		pc++;
		chk({30'h0, halted, osc_stop}, 32'h3);
		// Status bit 4 is power-down, bit 3 expired, bit 5 halted
		rd_chk(`REG_STATUS, 32'h38, 32'h28);
		rd_chk(`REG_WATCHDOG, 32'hffff, 32'h0);
		u_prog_mem.load(pc, 14'h3aff);
		step(2);
		rd_chk(`REG_PC, 32'h1fff, {19'h0, pc});
		wr(`REG_CTRL, 32'h3);
		chk({30'h0, halted, osc_stop}, 32'h0);
		// Disabled byte lane keeps the old accumulator value
		be <= 4'he;
		wr(`REG_ACC, 32'h55);
		be <= 4'hf;
		rd_chk(`REG_ACC, 32'hff, 32'hee);
		results();
	end
endmodule
